//--- src/irqp_bank.sv
/*
 * Interrupt mask, flag and level bank with APB register access.
 * Assumes peripheral requests are synchronous to pclk and the core samples
 * the registered grant. All state freezes while pclk_en is low.
 */
// Implementation choices: the register offsets and the APB slave port.
// Overview of operation
// RQ1: Mask bit 1 passes, 0 blocks; software accessible
// RQ2: Unimplemented bits read zero, ignore writes
// RQ3: Reset clears masks, levels load four
// RQ4: Level fields three bits; 111 is seven
// RQ5: Codes 001 upward map to levels 1-7
// RQ6: Level 000 disables source regardless of mask
// RQ7: Software routes external pin input to pin
// RQ8: Level word fields at 14:12,10:8,6:4,2:0
// RQ9: Mask one: pin2 bit13, pin1 bit4
// RQ10: Mask three: calendar 14, two-wire2 2,1
// RQ11: Mask four: checksum 3, serial errors 2,1
// RQ12: Flag sets on request, reads zero otherwise
// RQ13: Request needs flag, mask, nonzero level
// RQ14: Forward highest pending level with its level
`timescale 1ns/1ps
module irqp_bank (
	// Clock, reset, enable
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   pclk_en,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	input  wire logic [3:0]             pstrb,
	output logic                        pready,
	output logic [31:0]                 prdata,
	output logic                        pslverr,
	// Peripheral requests
	input  wire irqp_pkg::irqp_words_t  req,
	// Core side
	output logic                        irq,
	output irqp_pkg::irqp_grant_t       core_grant
);

	irqp_pkg::irqp_state_t                       s;
	irqp_pkg::irqp_state_t                       next_s;
	logic                                        setup;
	logic                                        wr;
	logic                                        hit;
	logic [3:0]                                  idx;
	logic [irqp_pkg::NSRC-1:0]                   qual;
	logic [irqp_pkg::NSRC-1:0][2:0]              lvl;
	irqp_pkg::irqp_grant_t                       grant;
	logic [15:0]                                 lane;
	logic [15:0]                                 rd_word;
	logic [irqp_pkg::NSRC-1:0]                   fflag;
	logic [irqp_pkg::NSRC-1:0]                   fmask;
	logic [irqp_pkg::NSRC-1:0]                   fimpl;

	irqp_apb_dec u_dec (
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pready  (s.pready),
		.setup   (setup),
		.wr      (wr),
		.hit     (hit),
		.idx     (idx)
	);

	// Flat views of the source words
	assign fflag = s.flag;
	assign fmask = s.mask;
	assign fimpl = irqp_pkg::IMPL_MASK;

	// Level of each source; sources outside the level word keep the default
	// Two loops keep every field select inside the level word
	always_comb begin
		for (int i = 0; i < irqp_pkg::NSRC; i++) begin
			lvl[i] = irqp_pkg::LEVEL_DEFAULT;
		end
		for (int i = 0; i < irqp_pkg::NLEVELED; i++) begin
			lvl[i] = s.level0[i*irqp_pkg::LVL_STRIDE +: 3]; // RQ4 RQ5 RQ8
		end
	end

	// Qualified sources: flag, mask and a nonzero level all needed
	always_comb begin
		for (int i = 0; i < irqp_pkg::NSRC; i++) begin
			qual[i] = fflag[i] && fmask[i] && fimpl[i] && (lvl[i] != irqp_pkg::LEVEL_OFF); // RQ1 RQ6 RQ13
		end
	end

	irqp_pick u_pick (
		.qual  (qual),
		.lvl   (lvl),
		.grant (grant)
	);

	// Byte lanes 0 and 1 carry the 16-bit registers
	assign lane = {{8{pstrb[1]}}, {8{pstrb[0]}}};

	// Read mux; unimplemented bits are already zero in state
	always_comb begin
		rd_word = 16'h0000;
		if (idx <= irqp_pkg::IDX_LEVEL0 - 4'h1)
			rd_word = s.mask[idx[2:0]];
		else if (idx == irqp_pkg::IDX_LEVEL0)
			rd_word = s.level0;
		else if (idx <= irqp_pkg::IDX_LAST)
			rd_word = s.flag[3'(idx - irqp_pkg::IDX_FLAG0)];
	end

	// Next state: request capture, APB answer, register writes, grant
	always_comb begin
		next_s         = s;
		next_s.pready  = 1'b0;
		next_s.pslverr = 1'b0;
		next_s.prdata  = 32'h0000_0000;
		// A request sets its flag; set wins over a clear in the same cycle
		for (int w = 0; w < irqp_pkg::NWORD; w++) begin
			next_s.flag[w] = s.flag[w] | (req[w] & irqp_pkg::IMPL_MASK[w]); // RQ12
		end
		// Answer one cycle after setup, so pready and prdata come from flops
		if (setup) begin
			next_s.pready  = 1'b1;
			next_s.pslverr = !hit;
			next_s.prdata  = hit ? {16'h0000, rd_word} : 32'h0000_0000;
		end
		if (wr) begin
			if (idx <= irqp_pkg::IDX_LEVEL0 - 4'h1) begin
				next_s.mask[idx[2:0]] = ((s.mask[idx[2:0]] & ~lane) | (pwdata[15:0] & lane))
					& irqp_pkg::IMPL_MASK[idx[2:0]]; // RQ1 RQ2 RQ9 RQ10 RQ11
			end else if (idx == irqp_pkg::IDX_LEVEL0) begin
				next_s.level0 = ((s.level0 & ~lane) | (pwdata[15:0] & lane))
					& irqp_pkg::LEVEL_IMPL; // RQ2 RQ8
			end else begin
				// Write one to clear; a fresh request still sets the flag
				next_s.flag[3'(idx - irqp_pkg::IDX_FLAG0)] =
					(s.flag[3'(idx - irqp_pkg::IDX_FLAG0)] & ~(pwdata[15:0] & lane))
					| (req[3'(idx - irqp_pkg::IDX_FLAG0)]
					& irqp_pkg::IMPL_MASK[3'(idx - irqp_pkg::IDX_FLAG0)]); // RQ12
			end
		end
		// Registered grant: one cycle behind the flags, kept glitch free
		next_s.irq   = grant.valid; // RQ13
		next_s.grant = grant; // RQ14
	end

	// State register; clock enable freezes everything
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s        <= '0;
			s.mask   <= irqp_pkg::MASK_RST; // RQ3
			s.flag   <= irqp_pkg::FLAG_RST;
			s.level0 <= irqp_pkg::LEVEL_RST; // RQ3
		end else if (pclk_en) begin
			s <= next_s;
		end
	end

	// Outputs straight from state flops
	assign pready     = s.pready;
	assign prdata     = s.prdata;
	assign pslverr    = s.pslverr;
	assign irq        = s.irq;
	assign core_grant = s.grant;

	// Helper for checks: previous flag-and-mask, previous qualification
	logic [irqp_pkg::NSRC-1:0] prev_fm;
	logic [irqp_pkg::NSRC-1:0] prev_qual;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_fm   <= '0;
			prev_qual <= '0;
		end else if (pclk_en) begin
			prev_fm   <= fflag & fmask;
			prev_qual <= qual;
		end
	end

	// Checks run on pclk and rest while reset or a low enable holds state
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn || !pclk_en);

	mask_write_a: assert property ( // RQ1
		wr && idx == 4'h1 && pstrb[1:0] == 2'h3 |=>
		s.mask[1] == ($past(pwdata[15:0]) & irqp_pkg::IMPL_MASK[1]))
		else $error("mask word not stored as written");

	unimpl_zero_a: assert property ( // RQ2
		s.mask[1][8:5] == 4'h0 && (s.level0 & ~irqp_pkg::LEVEL_IMPL) == 16'h0000
		&& (s.mask[3] & ~irqp_pkg::IMPL_MASK[3]) == 16'h0000)
		else $error("unimplemented bit holds a one");

	reset_value_a: assert property ( // RQ3
		$rose(presetn) |-> s.level0 == irqp_pkg::LEVEL_RST && s.mask == '0)
		else $error("reset values wrong");

	level_off_a: assert property ( // RQ6
		s.irq && s.grant.src == 7'h00 |-> $past(s.level0[2:0]) != irqp_pkg::LEVEL_OFF)
		else $error("disabled source forwarded");

	qual_cause_a: assert property ( // RQ13
		s.irq |-> prev_fm[s.grant.src] && $past(grant.valid))
		else $error("request without flag and mask");

	top_level_a: assert property ( // RQ14
		prev_qual[3] && $past(s.level0[irqp_pkg::TIMER1_LVL_LSB +: 3]) == irqp_pkg::LEVEL_TOP
		|-> s.irq && s.grant.level == irqp_pkg::LEVEL_TOP)
		else $error("level seven source not forwarded");

	flag_set_a: assert property ( // RQ12
		req[1][irqp_pkg::EXT_PIN2_BIT] |=> s.flag[1][irqp_pkg::EXT_PIN2_BIT] ##1
		(s.flag[1][irqp_pkg::EXT_PIN2_BIT] || $past(wr)))
		else $error("flag not set by request");

	level_map_a: assert property ( // RQ8
		wr && idx == irqp_pkg::IDX_LEVEL0 && pstrb[1:0] == 2'h3 && pwdata[15:0] == 16'hffff
		|=> s.level0 == irqp_pkg::LEVEL_IMPL)
		else $error("level fields misplaced");

	calendar_clr_a: assert property ( // RQ10
		wr && idx == irqp_pkg::IDX_FLAG0 + 4'h3 && pstrb[1] && pwdata[irqp_pkg::CALENDAR_BIT]
		&& !req[3][irqp_pkg::CALENDAR_BIT] |=> !s.flag[3][irqp_pkg::CALENDAR_BIT])
		else $error("calendar flag not cleared");

	checksum_bit_a: assert property ( // RQ11
		wr && idx == 4'h4 && pstrb[0] && pwdata[irqp_pkg::CHECKSUM_BIT]
		|=> s.mask[4][irqp_pkg::CHECKSUM_BIT] && !s.mask[4][0])
		else $error("checksum mask bit misplaced");

	apb_answer_a: assert property (
		setup |=> s.pready ##1 !s.pready || setup)
		else $error("no answer after setup");

	// Compare channel field reaches the grant unchanged
	level_code_a: assert property ( // RQ4 RQ5
		s.irq && s.grant.src == 7'd2
		|-> s.grant.level == $past(s.level0[irqp_pkg::COMPARE1_LVL_LSB +: 3]))
		else $error("grant level differs from level field");

	// Capture channel field reaches the grant unchanged
	capture_code_a: assert property ( // RQ5 RQ8
		s.irq && s.grant.src == 7'd1
		|-> s.grant.level == $past(s.level0[irqp_pkg::CAPTURE1_LVL_LSB +: 3]))
		else $error("capture level differs from level field");

	// External pin masks sit at their own bits of word one
	pin_masks_a: assert property ( // RQ9
		wr && idx == 4'h1 && pstrb[1:0] == 2'h3
		|=> s.mask[1][irqp_pkg::EXT_PIN2_BIT] == $past(pwdata[irqp_pkg::EXT_PIN2_BIT])
		&& s.mask[1][irqp_pkg::EXT_PIN1_BIT] == $past(pwdata[irqp_pkg::EXT_PIN1_BIT]))
		else $error("pin mask bit misplaced");

	// Second two-wire port masks sit at bits two and one of word three
	twowire_bits_a: assert property ( // RQ10
		wr && idx == 4'h3 && pstrb[0]
		|=> s.mask[3][irqp_pkg::TW2_MASTER_BIT] == $past(pwdata[irqp_pkg::TW2_MASTER_BIT])
		&& s.mask[3][irqp_pkg::TW2_SLAVE_BIT] == $past(pwdata[irqp_pkg::TW2_SLAVE_BIT]))
		else $error("two-wire mask bit misplaced");

	// Serial error masks sit at bits two and one of word four
	serial_err_a: assert property ( // RQ11
		wr && idx == 4'h4 && pstrb[0]
		|=> s.mask[4][irqp_pkg::SER2_ERR_BIT] == $past(pwdata[irqp_pkg::SER2_ERR_BIT])
		&& s.mask[4][irqp_pkg::SER1_ERR_BIT] == $past(pwdata[irqp_pkg::SER1_ERR_BIT]))
		else $error("serial error mask bit misplaced");

	// Gaps of mask and flag words never hold a one
	gap_bits_a: assert property ( // RQ2
		(s.mask & ~irqp_pkg::IMPL_MASK) == '0 && (s.flag & ~irqp_pkg::IMPL_MASK) == '0)
		else $error("gap bit holds a one");

	// Unmapped access answers with an error and zero data
	unmapped_err_a: assert property (
		setup && !hit |=> s.pready && s.pslverr && s.prdata == 32'h0000_0000)
		else $error("unmapped access not refused");

	// Read data and error stand only with pready
	rd_idle_a: assert property (
		!s.pready |-> s.prdata == 32'h0000_0000 && !s.pslverr)
		else $error("read data outside the answer");

	// An all-zero mask keeps the request line low
	mask_block_a: assert property ( // RQ1
		$past(s.mask == '0) |-> !s.irq)
		else $error("masked source forwarded");

	// A low enable holds every state bit; needs its own disable condition
	enable_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
		!pclk_en |=> s == $past(s))
		else $error("state moved while enable low");

	// Main scenarios the bench is expected to reach
	irq_cover_c:   cover property (s.irq);
	write_cover_c: cover property (wr && idx == irqp_pkg::IDX_LEVEL0);
	top_cover_c:   cover property (s.irq && s.grant.level == irqp_pkg::LEVEL_TOP);
	clear_cover_c: cover property (wr && idx >= irqp_pkg::IDX_FLAG0);
	hold_cover_c:  cover property (@(posedge pclk) disable iff (!presetn) !pclk_en);

endmodule // irqp_bank

//--- src/irqp_pkg.sv
/*
 * Shared constants and types of the interrupt mask and level bank.
 * Assumes a 32-bit APB master on pclk and peripheral requests on the same clock.
 */
package irqp_pkg;

	// Sizes: five 16-bit words of sources, 80 sources in all
	localparam int NWORD = 5;
	localparam int NSRC  = 80;

	typedef logic [NWORD-1:0][15:0] irqp_words_t;
	typedef logic [6:0]             irqp_src_t;
	typedef logic [2:0]             irqp_level_t;

	// Register index; byte address is four times the index
	localparam logic [3:0] IDX_MASK0  = 4'h0;
	localparam logic [3:0] IDX_LEVEL0 = 4'h5;
	localparam logic [3:0] IDX_FLAG0  = 4'h6;
	localparam logic [3:0] IDX_LAST   = 4'ha;

	// Implemented bits of each mask and flag word, word 0 lowest
	localparam irqp_words_t IMPL_MASK = {16'h210e, 16'h4006, 16'h22e3, 16'hfe1f, 16'h000f};
	localparam logic [15:0] LEVEL_IMPL = 16'h7777;

	// Values after reset
	localparam irqp_words_t MASK_RST  = '0;
	localparam irqp_words_t FLAG_RST  = '0;
	localparam logic [15:0] LEVEL_RST = 16'h4444;

	// Level fields: source j of word 0 uses bits 4*j+2 .. 4*j
	localparam int TIMER1_LVL_LSB   = 12;
	localparam int COMPARE1_LVL_LSB = 8;
	localparam int CAPTURE1_LVL_LSB = 4;
	localparam int EXT_PIN0_LVL_LSB = 0;
	localparam int LVL_STRIDE       = 4;
	localparam int NLEVELED         = 4;

	// Named bit positions inside mask and flag words
	localparam int EXT_PIN2_BIT  = 13;
	localparam int EXT_PIN1_BIT  = 4;
	localparam int CALENDAR_BIT  = 14;
	localparam int TW2_MASTER_BIT = 2;
	localparam int TW2_SLAVE_BIT = 1;
	localparam int CHECKSUM_BIT  = 3;
	localparam int SER2_ERR_BIT  = 2;
	localparam int SER1_ERR_BIT  = 1;

	// Level codes
	localparam irqp_level_t LEVEL_OFF     = 3'h0;
	localparam irqp_level_t LEVEL_TOP     = 3'h7;
	localparam irqp_level_t LEVEL_DEFAULT = 3'h4;

	// Forwarded request to the core
	typedef struct packed {
		logic        valid;
		irqp_src_t   src;
		irqp_level_t level;
	} irqp_grant_t;

	// All state of the top module
	typedef struct packed {
		irqp_words_t mask;
		irqp_words_t flag;
		logic [15:0] level0;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        irq;
		irqp_grant_t grant;
	} irqp_state_t;

endpackage

//--- src/irqp_apb_dec.sv
/*
 * APB address decoder for the bank.
 * Assumes the top registers pready; a write is taken only in the access edge.
 */
`timescale 1ns/1ps
module irqp_apb_dec (
	// APB request
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic        pready,
	// Decoded strobes
	output logic             setup,
	output logic             wr,
	output logic             hit,
	output logic [3:0]       idx
);

	// Word index and hit; misaligned or high addresses are unmapped
	always_comb begin
		idx   = paddr[5:2];
		hit   = (paddr[1:0] == 2'h0) && (paddr[11:6] == 6'h00) && (idx <= irqp_pkg::IDX_LAST);
		setup = psel && !penable;
		wr    = psel && penable && pready && pwrite && hit;
	end

endmodule // irqp_apb_dec

//--- src/irqp_pick.sv
/*
 * Highest-level picker over all qualified sources.
 * Assumes qual is already low for disabled sources.
 */
`timescale 1ns/1ps
module irqp_pick (
	// Candidates
	input  wire logic [irqp_pkg::NSRC-1:0]                         qual,
	input  wire logic [irqp_pkg::NSRC-1:0][2:0]                    lvl,
	// Winner
	output irqp_pkg::irqp_grant_t                                  grant
);

	// Strictly greater wins, so ties go to the lowest source number
	always_comb begin
		grant = '0;
		for (int i = 0; i < irqp_pkg::NSRC; i++) begin
			if (qual[i] && (!grant.valid || lvl[i] > grant.level)) begin
				grant.valid = 1'b1;
				grant.src   = irqp_pkg::irqp_src_t'(i);
				grant.level = lvl[i];
			end
		end
	end

endmodule // irqp_pick

//--- testbench/irqp_core_model.sv
/*
 * Sink model of the core: records each forwarded request while the line is high.
 * Assumes the bank drives a registered grant on pclk.
 */
`timescale 1ns/1ps
module irqp_core_model (
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// Request from the bank
	input  wire logic                  irq,
	input  wire irqp_pkg::irqp_grant_t core_grant,
	// Last request taken
	output irqp_pkg::irqp_grant_t      taken
);
	// No acknowledge goes back, so the core only records what it would vector to
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			taken <= '0;
		end else if (irq && core_grant.valid) begin
			taken <= core_grant;
		end
	end
endmodule // irqp_core_model

//--- testbench/irqp_bank_tb.sv
/*
 * Testbench of the mask and level bank: APB tasks and request scenarios.
 * Assumes the bank and a core model on one 10 MHz clock.
 */
`timescale 1ns/1ps
module irqp_bank_tb;
	logic                  pclk = 1'b0;
	logic                  presetn = 1'b0;
	logic                  pclk_en = 1'b1;
	logic                  psel = 1'b0;
	logic                  penable = 1'b0;
	logic                  pwrite = 1'b0;
	logic [11:0]           paddr = 12'h000;
	logic [31:0]           pwdata = 32'h0;
	logic [3:0]            pstrb = 4'h3;
	logic                  pready;
	logic [31:0]           prdata;
	logic                  pslverr;
	irqp_pkg::irqp_words_t req = '0;
	logic                  irq;
	irqp_pkg::irqp_grant_t core_grant;
	irqp_pkg::irqp_grant_t taken;
	int                    miscompares = 0;
	int                    total_checks = 0;
	logic [31:0]           rd;
	logic                  err;
	// Implemented mask bits of words one to four, from the register layouts
	logic [15:0]           impl [1:4] = '{16'hfe1f, 16'h22e3, 16'h4006, 16'h210e};

	// 100 ns period
	always #50 pclk = ~pclk;

	irqp_bank i_dut (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .req(req), .irq(irq),
		.core_grant(core_grant));

	irqp_core_model i_core (.pclk(pclk), .presetn(presetn), .irq(irq),
		.core_grant(core_grant), .taken(taken));

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; the request is held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [15:0] data);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= {16'h0, data};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			miscompares++;
			results();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rchk(input logic [11:0] addr, input logic [31:0] exp, input logic experr);
		apb(1'b0, addr, 16'h0);
		chk(rd, exp);
		chk({31'h0, err}, {31'h0, experr});
	endtask

	// Single-cycle request pulse on one word
	task automatic pulse(input int w, input logic [15:0] bits);
		req[w] <= bits;
		@(posedge pclk);
		req[w] <= 16'h0;
		@(posedge pclk);
	endtask

	task automatic wait_irq(input logic exp);
		int n;
		n = 0;
		while (irq !== exp && n < 10) begin
			@(posedge pclk);
			n++;
		end
		chk({31'h0, irq}, {31'h0, exp});
		if (irq !== exp) begin
			results();
		end
	endtask

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset value, writable implemented bits, zero-reading gaps
		for (int i = 1; i <= 4; i++) begin
			rchk(12'(4 * i), 32'h0, 1'b0);
			apb(1'b1, 12'(4 * i), 16'hffff);
			rchk(12'(4 * i), {16'h0, impl[i]}, 1'b0);
			apb(1'b1, 12'(4 * i), 16'h0000);
			rchk(12'(4 * i), 32'h0, 1'b0);
		end
		rchk(12'h014, 32'h4444, 1'b0);
		apb(1'b1, 12'h014, 16'hffff);
		rchk(12'h014, 32'h7777, 1'b0);
		// Unmapped place is refused and reads zero
		apb(1'b1, 12'h040, 16'hffff);
		chk({31'h0, err}, 32'h1);
		rchk(12'h040, 32'h0, 1'b1);
		chk({31'h0, pready}, 32'h0);
		// Levels: timer1 1, compare1 2, capture1 3, pin0 off
		apb(1'b1, 12'h000, 16'h000f);
		apb(1'b1, 12'h014, 16'h1230);
		pulse(0, 16'h000f); // pin input assumed routed by software
		wait_irq(1'b1);
		chk(32'(core_grant), {21'h0, 1'b1, 7'd1, 3'd3});
		rchk(12'h018, 32'h000f, 1'b0);
		apb(1'b1, 12'h018, 16'h0002);
		repeat (3) @(posedge pclk);
		chk(32'(core_grant), {21'h0, 1'b1, 7'd2, 3'd2});
		apb(1'b1, 12'h014, 16'h7230);
		repeat (3) @(posedge pclk);
		chk(32'(core_grant), {21'h0, 1'b1, 7'd3, 3'd7});
		// Mask off blocks, flags still pending
		apb(1'b1, 12'h000, 16'h0000);
		wait_irq(1'b0);
		apb(1'b1, 12'h018, 16'h000f);
		apb(1'b1, 12'h000, 16'h000f);
		repeat (3) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		// Pin two in word one at its default level
		apb(1'b1, 12'h004, 16'h2000);
		pulse(1, 16'h2000);
		wait_irq(1'b1);
		chk(32'(core_grant), {21'h0, 1'b1, 7'd29, 3'd4});
		repeat (2) @(posedge pclk);
		chk(32'(taken), {21'h0, 1'b1, 7'd29, 3'd4});
		// Low enable: a request pulse is not captured; then it is, and clears
		pclk_en <= 1'b0;
		pulse(3, 16'h4000);
		pclk_en <= 1'b1;
		rchk(12'h024, 32'h0, 1'b0);
		pulse(3, 16'h4000);
		rchk(12'h024, 32'h4000, 1'b0);
		apb(1'b1, 12'h024, 16'h4000);
		rchk(12'h024, 32'h0, 1'b0);
		results();
	end
endmodule // irqp_bank_tb
